// ### pkg/plm_pkg.sv
// Package with register map, field positions, reset values and types
package plm_pkg;
  // Register offsets on the plain register port (byte addresses)
  localparam logic [11:0] OFS_XCOEF = 12'h000;
  localparam logic [11:0] OFS_PCOEF = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_MASK = 12'h014;
  localparam logic [11:0] OFS_CYCLES = 12'h018;
  localparam logic [11:0] OFS_WIRING = 12'h01c;
  localparam logic [11:0] OFS_SLOTCAL = 12'h020;
  localparam logic [11:0] OFS_AP0 = 12'h024;
  localparam logic [11:0] OFS_AP1 = 12'h028;
  localparam logic [11:0] OFS_NZLIM = 12'h02c;
  localparam logic [11:0] OFS_FREQ = 12'h030;
  localparam logic [11:0] OFS_PERIOD = 12'h08c;
  // Saved accumulators: base + 4 * index, index 0..8
  localparam logic [11:0] OFS_ACC_BASE = 12'h100;
  localparam logic [11:0] OFS_ACC_LAST = 12'h120;
  // Status and mask bit positions
  localparam int BIT_SNAP = 0;
  localparam int BIT_OVR = 1;
  localparam int BIT_NO_CROSSING_FLAG = 11;
  localparam int BIT_SEQ = 15;
  // Reset values
  localparam logic [15:0] RST_XCOEF = 16'h0800;
  localparam logic [15:0] RST_PCOEF = 16'h1000;
  localparam logic [15:0] RST_PERIOD = 16'h0064;
  localparam logic [7:0] RST_CYCLES = 8'h01;
  localparam logic [1:0] RST_WIRING = 2'h0;
  localparam logic [15:0] RST_SLOTCAL = 16'h61a8;
  localparam logic [15:0] RST_AP0 = 16'h4000;
  localparam logic [15:0] RST_AP1 = 16'h4000;
  localparam logic [15:0] RST_NZLIM = 16'h0190;
  // Frame geometry and arithmetic sizes
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [3:0] LAST_ACC = 4'h8;
  localparam int ACC_W = 48;
  localparam int MEM_AW = 5;
  localparam logic [5:0] DIV_STEPS = 6'h28;
  // 10^12: slot period in ns to line frequency in mHz
  localparam logic [39:0] FREQ_NUM = 40'he8d4a51000;
  // Accumulator sweep states
  typedef enum logic [0:0] {
    PLM_IDLE = 1'b0,
    PLM_SWEEP = 1'b1
  } plm_sweep_t;
  // Second power accumulator modes
  typedef enum logic [1:0] {
    PLM_WYE = 2'b00,
    PLM_SPLIT = 2'b01,
    PLM_DELTA = 2'b10
  } plm_wiring_t;
endpackage

// ### pkg/plm_mem_if.sv
// Interface between the monitor and its accumulator memory
`timescale 1ns/1ps
`default_nettype none
interface plm_mem_if;
  logic [plm_pkg::MEM_AW-1:0] a_addr; // Sweep read address
  logic [plm_pkg::ACC_W-1:0] a_q; // Sweep read data, registered
  logic [plm_pkg::MEM_AW-1:0] b_addr; // Register port read address
  logic [plm_pkg::ACC_W-1:0] b_q; // Register port read data, registered
  logic wr_en; // Write strobe
  logic [plm_pkg::MEM_AW-1:0] wr_addr; // Write address
  logic [plm_pkg::ACC_W-1:0] wr_data; // Write data
  modport mem (input a_addr, b_addr, wr_en, wr_addr, wr_data,
               output a_q, b_q);
  modport user (output a_addr, b_addr, wr_en, wr_addr, wr_data,
                input a_q, b_q);
endinterface
`default_nettype wire

// ### hdl/plm_acc_mem.sv
// Two-bank accumulator memory with two registered read ports
`timescale 1ns/1ps
`default_nettype none
module plm_acc_mem (
  // Clock
  input wire logic sys_clk,
  // Memory port
  plm_mem_if.mem m
);
  // Storage; contents are undefined until first written
  logic [plm_pkg::ACC_W-1:0] mem_ff [2**plm_pkg::MEM_AW];

  // Write and both read registers share one edge
  always_ff @(posedge sys_clk) begin
    if (m.wr_en) begin
      mem_ff[m.wr_addr] <= m.wr_data;
    end
    m.a_q <= mem_ff[m.a_addr];
    m.b_q <= mem_ff[m.b_addr];
  end
endmodule
`default_nettype wire

// ### hdl/plm_line_monitor.sv
// Polyphase line monitor: crossing, period, frequency and accumulators
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module plm_line_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Sample stream
  input wire logic slot_tick,
  input wire logic smp_valid,
  input wire logic [15:0] va,
  input wire logic [15:0] vb,
  input wire logic [15:0] vc,
  input wire logic [15:0] ia,
  input wire logic [15:0] ib,
  input wire logic [15:0] ic,
  // Event outputs
  output logic line_cycle_trig,
  output logic post_trig,
  output logic irq_n
);
  plm_mem_if mif ();

  // Accumulator memory
  plm_acc_mem u_mem (
    .sys_clk(sys_clk),
    .m(mif)
  );

  // Settings written by the master
  logic [15:0] xcoef_ff, pcoef_ff, tc_ff, ap0_ff, ap1_ff, nzlim_ff;
  logic [7:0] cyc_ff;
  logic [1:0] wiring_ff;
  logic mask_nz_ff, mask_seq_ff;
  // Status flags
  logic snap_ff, ovr_ff, no_crossing_flag_ff, seq_ff;

  // Write decode
  wire wr_xcoef = reg_wr && (reg_addr == plm_pkg::OFS_XCOEF);
  wire wr_pcoef = reg_wr && (reg_addr == plm_pkg::OFS_PCOEF);
  wire wr_status = reg_wr && (reg_addr == plm_pkg::OFS_STATUS);
  wire wr_mask = reg_wr && (reg_addr == plm_pkg::OFS_MASK);
  wire wr_cycles = reg_wr && (reg_addr == plm_pkg::OFS_CYCLES);
  wire wr_wiring = reg_wr && (reg_addr == plm_pkg::OFS_WIRING);
  wire wr_slotcal = reg_wr && (reg_addr == plm_pkg::OFS_SLOTCAL);
  wire wr_ap0 = reg_wr && (reg_addr == plm_pkg::OFS_AP0);
  wire wr_ap1 = reg_wr && (reg_addr == plm_pkg::OFS_AP1);
  wire wr_nzlim = reg_wr && (reg_addr == plm_pkg::OFS_NZLIM);
  wire wr_period = reg_wr && (reg_addr == plm_pkg::OFS_PERIOD);

  // Plain settings registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xcoef_ff <= plm_pkg::RST_XCOEF;
      pcoef_ff <= plm_pkg::RST_PCOEF;
      cyc_ff <= plm_pkg::RST_CYCLES;
      wiring_ff <= plm_pkg::RST_WIRING;
      tc_ff <= plm_pkg::RST_SLOTCAL;
      ap0_ff <= plm_pkg::RST_AP0;
      ap1_ff <= plm_pkg::RST_AP1;
      nzlim_ff <= plm_pkg::RST_NZLIM;
      mask_nz_ff <= 1'b0;
      mask_seq_ff <= 1'b0;
    end else begin
      if (wr_xcoef) xcoef_ff <= reg_wdata[15:0];
      if (wr_pcoef) pcoef_ff <= reg_wdata[15:0];
      if (wr_cycles) cyc_ff <= reg_wdata[7:0];
      if (wr_wiring) wiring_ff <= reg_wdata[1:0];
      if (wr_slotcal) tc_ff <= reg_wdata[15:0];
      if (wr_ap0) ap0_ff <= reg_wdata[15:0];
      if (wr_ap1) ap1_ff <= reg_wdata[15:0];
      if (wr_nzlim) nzlim_ff <= reg_wdata[15:0];
      if (wr_mask) begin
        mask_nz_ff <= reg_wdata[plm_pkg::BIT_NO_CROSSING_FLAG];
        mask_seq_ff <= reg_wdata[plm_pkg::BIT_SEQ];
      end
    end
  end

  // Frame timing: disabled slots still take their time, so a frame end
  // is every eighth slot tick regardless of which slots convert
  logic [2:0] slot_cnt_ff;
  wire frame_end = slot_tick && (slot_cnt_ff == plm_pkg::LAST_SLOT);
  always_ff @(posedge sys_clk) begin
    if (rst) slot_cnt_ff <= 3'h0;
    else if (slot_tick) slot_cnt_ff <= slot_cnt_ff + 3'h1;
  end

  // Per-phase crossing filter, crossing detector and period counter
  logic signed [15:0] vin [3];
  logic [15:0] raw [3];
  logic [2:0] xing, pend, seen, svc;
  assign vin[0] = va;
  assign vin[1] = vb;
  assign vin[2] = vc;

  for (genvar p = 0; p < 3; p++) begin : g_ph
    logic signed [31:0] lpf_ff; // Q16.16 filtered voltage
    logic signed [32:0] lpf_err;
    logic signed [49:0] lpf_step;
    logic signed [31:0] lpf_nxt;
    logic [15:0] cnt_ff, raw_ff;
    logic seen_ff, pend_ff;
    assign lpf_err = 33'($signed({vin[p], 16'h0000})) - 33'(lpf_ff);
    assign lpf_step = lpf_err * $signed({1'b0, xcoef_ff});
    assign lpf_nxt = lpf_ff + 32'(lpf_step >>> 16);
    // Ascending: filtered value goes from negative to non-negative
    assign xing[p] = smp_valid && lpf_ff[31] && !lpf_nxt[31];
    assign raw[p] = raw_ff;
    assign pend[p] = pend_ff;
    assign seen[p] = seen_ff;
    // Filter state updates once per sample
    always_ff @(posedge sys_clk) begin
      if (rst) lpf_ff <= 32'h0000_0000;
      else if (smp_valid) lpf_ff <= lpf_nxt;
    end
    // Frame counter restarts at each crossing; first crossing only arms
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        cnt_ff <= 16'h0000;
        raw_ff <= 16'h0000;
        seen_ff <= 1'b0;
        pend_ff <= 1'b0;
      end else begin
        if (xing[p]) begin
          cnt_ff <= frame_end ? 16'h0001 : 16'h0000;
          raw_ff <= frame_end ? cnt_ff + 16'h0001 : cnt_ff;
          seen_ff <= 1'b1;
        end else if (frame_end && (cnt_ff != 16'hffff)) begin
          cnt_ff <= cnt_ff + 16'h0001;
        end
        // New measurement wins over its own service
        pend_ff <= (xing[p] && seen_ff) || (pend_ff && !svc[p]);
      end
    end
  end

  // Global period filter, one pending measurement served per cycle
  logic [31:0] g_ff; // Q16.16 frames per line cycle
  assign svc = pend[0] ? 3'b001 : pend[1] ? 3'b010 : pend[2] ? 3'b100 : 3'b000;
  wire [15:0] raw_sel = svc[0] ? raw[0] : svc[1] ? raw[1] : raw[2];
  wire signed [32:0] g_err = 33'($signed({1'b0, raw_sel, 16'h0000}))
                             - 33'($signed({1'b0, g_ff}));
  wire signed [48:0] g_step = g_err * $signed(pcoef_ff);
  wire [15:0] ns_int = g_ff[31:16];
  always_ff @(posedge sys_clk) begin
    if (rst) g_ff <= {plm_pkg::RST_PERIOD, 16'h0000};
    else if (wr_period) g_ff <= {reg_wdata[15:0], 16'h0000};
    else if (|svc) g_ff <= g_ff + 32'(g_step >>> 16);
  end

  // Line-cycle trigger every ns_int frames
  logic [15:0] lc_cnt_ff;
  logic line_cycle_trig_ff;
  wire lc_hit = frame_end && ((lc_cnt_ff + 16'h0001) >= ns_int);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lc_cnt_ff <= 16'h0000;
      line_cycle_trig_ff <= 1'b0;
    end else begin
      line_cycle_trig_ff <= lc_hit;
      if (lc_hit) lc_cnt_ff <= 16'h0000;
      else if (frame_end) lc_cnt_ff <= lc_cnt_ff + 16'h0001;
    end
  end
  assign line_cycle_trig = line_cycle_trig_ff;

  // Missing crossings: frames since the last crossing on any phase
  logic [15:0] nz_cnt_ff;
  wire nz_hit = (nz_cnt_ff >= nzlim_ff);
  always_ff @(posedge sys_clk) begin
    if (rst) nz_cnt_ff <= 16'h0000;
    else if (|xing) nz_cnt_ff <= 16'h0000;
    else if (frame_end && !nz_hit) nz_cnt_ff <= nz_cnt_ff + 16'h0001;
  end

  // Phase order: 1 = A, 2 = B, 3 = C, 0 = none yet
  logic [1:0] last_ph_ff;
  wire [1:0] new_ph = xing[0] ? 2'h1 : xing[1] ? 2'h2 : 2'h3;
  wire seq_hit = (|xing) && (&seen) && (last_ph_ff == 2'h1)
                 && (new_ph == 2'h3);
  always_ff @(posedge sys_clk) begin
    if (rst) last_ph_ff <= 2'h0;
    else if (|xing) last_ph_ff <= new_ph;
  end

  // Accumulation period; no trigger inside a sweep so banks never split
  logic [23:0] acc_cnt_ff;
  logic post_trig_ff, bank_ff, fresh_ff;
  plm_pkg::plm_sweep_t st_ff;
  wire [23:0] acc_limit = {16'h0000, cyc_ff} * {8'h00, ns_int};
  wire trig = (acc_cnt_ff > acc_limit) && (st_ff == plm_pkg::PLM_IDLE);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_cnt_ff <= 24'h000000;
      post_trig_ff <= 1'b0;
    end else begin
      post_trig_ff <= trig;
      if (trig) acc_cnt_ff <= 24'h000000;
      else if (frame_end) acc_cnt_ff <= acc_cnt_ff + 24'h000001;
    end
  end
  assign post_trig = post_trig_ff;

  // Status flags: hardware set wins over a master clear in the same cycle
  wire clr_snap = wr_status && !reg_wdata[plm_pkg::BIT_SNAP];
  wire clr_ovr = wr_status && !reg_wdata[plm_pkg::BIT_OVR];
  wire clr_no_crossing_flag = wr_status && !reg_wdata[plm_pkg::BIT_NO_CROSSING_FLAG];
  wire clr_seq = wr_status && !reg_wdata[plm_pkg::BIT_SEQ];
  logic irq_n_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      snap_ff <= 1'b0;
      ovr_ff <= 1'b0;
      no_crossing_flag_ff <= 1'b0;
      seq_ff <= 1'b0;
      irq_n_ff <= 1'b1;
    end else begin
      snap_ff <= trig || (snap_ff && !clr_snap);
      // Unacknowledged snapshot overwritten: data lost
      ovr_ff <= (trig && snap_ff) || (ovr_ff && !clr_ovr);
      no_crossing_flag_ff <= nz_hit || (no_crossing_flag_ff && !clr_no_crossing_flag);
      seq_ff <= seq_hit || (seq_ff && !clr_seq);
      irq_n_ff <= !((no_crossing_flag_ff && mask_nz_ff) || (seq_ff && mask_seq_ff));
    end
  end
  assign irq_n = irq_n_ff;

  // Sample latch, with previous A and C for the all-pass sum
  logic signed [15:0] va_ff, vb_ff, vc_ff, ia_ff, ib_ff, ic_ff;
  logic signed [15:0] va_prev_ff, vc_prev_ff;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      {va_ff, vb_ff, vc_ff} <= 48'h0;
      {ia_ff, ib_ff, ic_ff} <= 48'h0;
      {va_prev_ff, vc_prev_ff} <= 32'h0;
    end else if (smp_valid) begin
      {va_ff, vb_ff, vc_ff} <= {va, vb, vc};
      {ia_ff, ib_ff, ic_ff} <= {ia, ib, ic};
      {va_prev_ff, vc_prev_ff} <= {va_ff, vc_ff};
    end
  end

  // All-pass sum of A and C voltages
  wire signed [16:0] ap_s0 = 17'(vc_ff) + 17'(va_prev_ff);
  wire signed [16:0] ap_s1 = 17'(vc_prev_ff) + 17'(va_ff);
  // Operands widen before the product so the full 33-bit result survives
  wire signed [33:0] ap_acc = 34'($signed(ap0_ff)) * 34'(ap_s0)
                            + 34'($signed(ap1_ff)) * 34'(ap_s1);
  wire signed [17:0] vac = ap_acc[33:16];

  // Sweep: one read per entry, write-back one cycle later
  logic [3:0] idx_ff, wr_idx_ff;
  logic wr_act_ff;
  logic signed [17:0] op_a, op_b;
  wire signed [17:0] neg_ib = -18'(ib_ff);
  always_comb begin
    op_a = 18'(va_ff);
    op_b = 18'(ia_ff);
    case (wr_idx_ff)
      4'h0: begin
        op_a = 18'(va_ff);
        op_b = 18'(ia_ff);
      end
      4'h1: begin
        case (wiring_ff)
          plm_pkg::PLM_WYE: begin
            op_a = 18'(vb_ff);
            op_b = 18'(ib_ff);
          end
          plm_pkg::PLM_SPLIT: begin
            op_a = neg_ib;
            op_b = vac;
          end
          default: begin
            op_a = neg_ib;
            op_b = 18'(va_ff);
          end
        endcase
      end
      4'h2: begin
        op_a = 18'(vc_ff);
        op_b = 18'(ic_ff);
      end
      // Squares for the RMS integrals of each phase
      4'h3: begin
        op_a = 18'(va_ff);
        op_b = 18'(va_ff);
      end
      4'h4: begin
        op_a = 18'(vb_ff);
        op_b = 18'(vb_ff);
      end
      4'h5: begin
        op_a = 18'(vc_ff);
        op_b = 18'(vc_ff);
      end
      4'h6: begin
        op_a = 18'(ia_ff);
        op_b = 18'(ia_ff);
      end
      4'h7: begin
        op_a = 18'(ib_ff);
        op_b = 18'(ib_ff);
      end
      default: begin
        op_a = 18'(ic_ff);
        op_b = 18'(ic_ff);
      end
    endcase
  end
  wire signed [35:0] prod = op_a * op_b;
  wire [plm_pkg::ACC_W-1:0] term = plm_pkg::ACC_W'(prod);
  // Fresh bank entries start from the term alone, which is the clear
  wire [plm_pkg::ACC_W-1:0] acc_sum = (fresh_ff ? '0 : mif.a_q) + term;

  // Sweep control and bank swap; accumulation never stops
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= plm_pkg::PLM_IDLE;
      idx_ff <= 4'h0;
      wr_idx_ff <= 4'h0;
      wr_act_ff <= 1'b0;
      bank_ff <= 1'b0;
      fresh_ff <= 1'b1;
    end else begin
      wr_act_ff <= (st_ff == plm_pkg::PLM_SWEEP);
      wr_idx_ff <= idx_ff;
      if (trig) begin
        bank_ff <= !bank_ff;
        fresh_ff <= 1'b1;
      end else if (wr_act_ff && (wr_idx_ff == plm_pkg::LAST_ACC)) begin
        fresh_ff <= 1'b0;
      end
      case (st_ff)
        plm_pkg::PLM_IDLE: begin
          idx_ff <= 4'h0;
          if (smp_valid) st_ff <= plm_pkg::PLM_SWEEP;
        end
        plm_pkg::PLM_SWEEP: begin
          idx_ff <= idx_ff + 4'h1;
          if (idx_ff == plm_pkg::LAST_ACC) st_ff <= plm_pkg::PLM_IDLE;
        end
        default: st_ff <= plm_pkg::PLM_IDLE;
      endcase
    end
  end
  assign mif.a_addr = {bank_ff, idx_ff};
  assign mif.wr_en = wr_act_ff;
  assign mif.wr_addr = {bank_ff, wr_idx_ff};
  assign mif.wr_data = acc_sum;

  // Line frequency in mHz: 10^12 / (frames * slot period in ns)
  logic [5:0] div_cnt_ff;
  logic [31:0] rem_ff, dvs_ff, freq_ff;
  logic [39:0] quo_ff;
  wire [32:0] rem_sh = {rem_ff, quo_ff[39]};
  wire div_ge = (rem_sh >= {1'b0, dvs_ff});
  wire [32:0] rem_sub = rem_sh - {1'b0, dvs_ff};
  wire [31:0] rem_nxt = div_ge ? rem_sub[31:0] : rem_sh[31:0];
  wire [39:0] quo_nxt = {quo_ff[38:0], div_ge};
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_cnt_ff <= 6'h00;
      rem_ff <= 32'h0;
      dvs_ff <= 32'h0;
      quo_ff <= 40'h0;
      freq_ff <= 32'h0;
    end else if (div_cnt_ff == 6'h00) begin
      div_cnt_ff <= 6'h01;
      rem_ff <= 32'h0;
      quo_ff <= plm_pkg::FREQ_NUM;
      dvs_ff <= {16'h0000, ns_int} * {16'h0000, tc_ff};
    end else begin
      rem_ff <= rem_nxt;
      quo_ff <= quo_nxt;
      div_cnt_ff <= div_cnt_ff + 6'h01;
      if (div_cnt_ff == plm_pkg::DIV_STEPS) begin
        div_cnt_ff <= 6'h00;
        freq_ff <= (dvs_ff == 32'h0) ? 32'h0 : quo_nxt[31:0];
      end
    end
  end

  // Register read: saved bank comes from the memory's read register
  wire acc_hit = (reg_addr >= plm_pkg::OFS_ACC_BASE)
                 && (reg_addr <= plm_pkg::OFS_ACC_LAST)
                 && (reg_addr[1:0] == 2'b00);
  wire [11:0] acc_ofs = reg_addr - plm_pkg::OFS_ACC_BASE;
  assign mif.b_addr = {!bank_ff, acc_ofs[5:2]};
  wire [31:0] status_word_one = {16'h0000, seq_ff, 3'h0, no_crossing_flag_ff, 9'h000,
                                 ovr_ff, snap_ff};
  wire [31:0] mask_word = {16'h0000, mask_seq_ff, 3'h0, mask_nz_ff, 11'h000};
  wire [31:0] rd_mux =
    (reg_addr == plm_pkg::OFS_XCOEF) ? {16'h0000, xcoef_ff} :
    (reg_addr == plm_pkg::OFS_PCOEF) ? {16'h0000, pcoef_ff} :
    (reg_addr == plm_pkg::OFS_STATUS) ? status_word_one :
    (reg_addr == plm_pkg::OFS_MASK) ? mask_word :
    (reg_addr == plm_pkg::OFS_CYCLES) ? {24'h000000, cyc_ff} :
    (reg_addr == plm_pkg::OFS_WIRING) ? {30'h0, wiring_ff} :
    (reg_addr == plm_pkg::OFS_SLOTCAL) ? {16'h0000, tc_ff} :
    (reg_addr == plm_pkg::OFS_AP0) ? {16'h0000, ap0_ff} :
    (reg_addr == plm_pkg::OFS_AP1) ? {16'h0000, ap1_ff} :
    (reg_addr == plm_pkg::OFS_NZLIM) ? {16'h0000, nzlim_ff} :
    (reg_addr == plm_pkg::OFS_FREQ) ? freq_ff :
    (reg_addr == plm_pkg::OFS_PERIOD) ? {16'h0000, ns_int} :
    32'h0000_0000;
  logic [31:0] rdata_ff;
  logic acc_sel_ff;
  // Unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= 32'h0;
      acc_sel_ff <= 1'b0;
    end else begin
      acc_sel_ff <= reg_rd && acc_hit;
      if (reg_rd) rdata_ff <= rd_mux;
    end
  end
  // Accumulator words read as their upper 32 of 48 bits
  assign reg_rdata = acc_sel_ff ? mif.b_q[47:16] : rdata_ff;
endmodule
`default_nettype wire

// ### bench/plm_chk_monitor.sv
// Port-level checker for the line monitor, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module plm_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Sample and event side
  input wire logic smp_valid,
  input wire logic line_cycle_trig,
  input wire logic post_trig,
  input wire logic irq_n
);
  logic [1:0] mask_ff; // Copy of the enables, {bit 15, bit 11}
  logic [3:0] quiet_ff; // Cycles since a sample, saturating
  logic st_rd; // Status read taken
  assign st_rd = reg_rd && reg_addr == plm_pkg::OFS_STATUS;
  // Follow the enables as the master writes them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_ff <= 2'h0;
    end else if (reg_wr && reg_addr == plm_pkg::OFS_MASK) begin
      mask_ff <= {reg_wdata[plm_pkg::BIT_SEQ], reg_wdata[plm_pkg::BIT_NO_CROSSING_FLAG]};
    end
  end
  // Period updates trail a sample, so only quiet spans are trusted
  always_ff @(posedge sys_clk) begin
    if (rst || smp_valid) begin
      quiet_ff <= 4'h0;
    end else if (quiet_ff != 4'hf) begin
      quiet_ff <= quiet_ff + 4'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_irq_cause;
    !irq_n |-> $past(mask_ff) != 2'h0;
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("irq low with both enables off");
  property p_rst_quiet;
    $fell(rst) |-> irq_n && !post_trig && !line_cycle_trig && !reg_rdata;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs not idle after reset");
  property p_line_pulse;
    line_cycle_trig |=> !line_cycle_trig [*7];
  endproperty
  a_line_pulse: assert property (p_line_pulse)
    else $error("line trigger closer than one frame");
  property p_post_gap;
    post_trig |=> !post_trig [*8];
  endproperty
  a_post_gap: assert property (p_post_gap)
    else $error("post trigger repeated during sweep");
  property p_unmapped;
    reg_rd && reg_addr == 12'h0fc |=> reg_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_period_rw;
    (reg_wr && reg_addr == plm_pkg::OFS_PERIOD && quiet_ff == 4'hf) ##2
      (reg_rd && reg_addr == plm_pkg::OFS_PERIOD)
      |=> reg_rdata == {16'h0, $past(reg_wdata[15:0], 3)};
  endproperty
  a_period_rw: assert property (p_period_rw)
    else $error("written period count not read back");
  property p_no_crossing_flag_irq;
    $past(st_rd) && reg_rdata[plm_pkg::BIT_NO_CROSSING_FLAG] && mask_ff[0]
      && $stable(mask_ff) |-> ##[0:1] !irq_n;
  endproperty
  a_no_crossing_flag_irq: assert property (p_no_crossing_flag_irq)
    else $error("enabled missing-crossing flag left irq high");
  property p_seq_irq;
    $past(st_rd) && reg_rdata[plm_pkg::BIT_SEQ] && mask_ff[1]
      && $stable(mask_ff) |-> ##[0:1] !irq_n;
  endproperty
  a_seq_irq: assert property (p_seq_irq)
    else $error("enabled order flag left irq high");
endmodule
bind plm_line_monitor plm_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .smp_valid(smp_valid),
  .line_cycle_trig(line_cycle_trig), .post_trig(post_trig), .irq_n(irq_n));
`default_nettype wire

// ### bench/plm_master.sv
// Register port master standing in for the external controller
`timescale 1ns/1ps
`default_nettype none
module plm_master (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic [11:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  // Idle from time zero; slot rate left at its roomy default
  initial begin
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write: period loads and flag clears go here
  task automatic wr(input logic [11:0] a, input logic [31:0] w);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~w;
  endtask
  // One-cycle read; data stands from the following cycle, accumulator words for that cycle only
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the polyphase line monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0; // 100 MHz
  logic rst = 1'b1;
  logic slot_tick = 1'b0;
  logic smp_valid = 1'b0;
  logic [15:0] v [6] = '{default: 16'h1000}; // va vb vc ia ib ic
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic line_cycle_trig;
  logic post_trig;
  logic irq_n;
  logic [31:0] d; // Last word read
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  int lcyc = 0; // Cycle of the last line trigger
  int lgap = 0; // Cycles between the last two line triggers
  int pc = 0; // Post triggers seen
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (post_trig === 1'b1) pc <= pc + 1;
    if (line_cycle_trig === 1'b1) begin
      lgap <= cyc - lcyc;
      lcyc <= cyc;
    end
  end
  plm_master u_m (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  plm_line_monitor dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .slot_tick(slot_tick), .smp_valid(smp_valid),
    .va(v[0]), .vb(v[1]), .vc(v[2]), .ia(v[3]), .ib(v[4]), .ic(v[5]),
    .line_cycle_trig(line_cycle_trig), .post_trig(post_trig),
    .irq_n(irq_n));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    u_m.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  // Status bits under mask m
  task automatic sbit(input logic [31:0] m, input logic [31:0] e);
    u_m.rd(plm_pkg::OFS_STATUS, d);
    chk("status", e, d & m);
  endtask
  // One frame of eight slots; bit p of pos makes phase p positive
  task automatic frame(input logic [2:0] pos);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      slot_tick <= 1'b1;
      smp_valid <= (i == 0);
      for (int p = 0; p < 3; p++) v[p] <= pos[p] ? 16'h3e80 : 16'hc180;
      @(posedge sys_clk);
      slot_tick <= 1'b0;
      smp_valid <= 1'b0;
    end
  endtask
  // Line frequency in mHz for a period count and a slot period in ns
  function automatic logic [31:0] exp_freq(input logic [31:0] a,
                                           input logic [31:0] b);
    logic [63:0] q;
    q = 64'he8d4a51000 / (a * b);
    return q[31:0];
  endfunction
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // About 1300 cycles of tests; over twenty times that means a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end
  initial begin
    logic [31:0] n;
    logic [31:0] s;
    int k;
    void'($urandom(70204));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rchk(plm_pkg::OFS_XCOEF, 32'h0800);
    rchk(plm_pkg::OFS_PCOEF, 32'h1000);
    rchk(plm_pkg::OFS_PERIOD, 32'h0064);
    rchk(plm_pkg::OFS_MASK, 32'h0);
    rchk(plm_pkg::OFS_CYCLES, 32'h01);
    rchk(plm_pkg::OFS_WIRING, 32'h0);
    rchk(plm_pkg::OFS_SLOTCAL, 32'h61a8);
    rchk(plm_pkg::OFS_AP1, 32'h4000);
    rchk(plm_pkg::OFS_NZLIM, 32'h0190);
    rchk(12'h0fc, 32'h0);
    $display("test reset done");
    n = $urandom % 128 + 50;
    s = $urandom % 20000 + 1000;
    u_m.wr(plm_pkg::OFS_PERIOD, n);
    rchk(plm_pkg::OFS_PERIOD, n);
    u_m.wr(plm_pkg::OFS_SLOTCAL, s);
    u_m.wr(plm_pkg::OFS_FREQ, 32'h0);
    repeat (100) @(posedge sys_clk);
    rchk(plm_pkg::OFS_FREQ, exp_freq(n, s));
    $display("test frequency done");
    u_m.wr(plm_pkg::OFS_PERIOD, 32'h4);
    for (k = 0; k < 10; k++) frame(3'h7);
    chk("line gap", 32'd64, lgap);
    for (int w = 0; w < 4; w++) begin
      u_m.wr(plm_pkg::OFS_WIRING, w);
      k = pc;
      while (pc < k + 2) frame(3'h7);
      repeat (12) @(posedge sys_clk);
      u_m.rd(plm_pkg::OFS_ACC_BASE, d);
      chk("acc first sign", 32'h0, {31'h0, d[31]});
      u_m.rd(12'h104, d);
      chk("acc second sign", w != 0, {31'h0, d[31]});
      u_m.rd(12'h108, d);
      chk("acc third sign", 32'h0, {31'h0, d[31]});
    end
    sbit(32'h1, 32'h1);
    $display("test accumulation done");
    u_m.wr(plm_pkg::OFS_NZLIM, 32'h3);
    u_m.wr(plm_pkg::OFS_MASK, 32'h0800);
    u_m.wr(plm_pkg::OFS_STATUS, 32'h0);
    for (k = 0; k < 5; k++) frame(3'h7);
    sbit(32'h0800, 32'h0800);
    chk("irq", 32'h0, irq_n);
    u_m.wr(plm_pkg::OFS_NZLIM, 32'hffff);
    u_m.wr(plm_pkg::OFS_STATUS, 32'h0);
    sbit(32'h0800, 32'h0);
    chk("irq", 32'h1, irq_n);
    $display("test no crossing done");
    u_m.wr(plm_pkg::OFS_XCOEF, 32'hffff);
    u_m.wr(plm_pkg::OFS_MASK, 32'h8000);
    frame(3'h0);
    frame(3'h1);
    frame(3'h3);
    frame(3'h7);
    frame(3'h0);
    sbit(32'h8000, 32'h0);
    frame(3'h1);
    frame(3'h5);
    sbit(32'h8000, 32'h8000);
    chk("irq", 32'h0, irq_n);
    u_m.wr(plm_pkg::OFS_STATUS, 32'h0);
    sbit(32'h8000, 32'h0);
    // A gave 4 frames (no change from 4), then C gave 3: 4 - 1/16
    rchk(plm_pkg::OFS_PERIOD, 32'h3);
    $display("test order done");
    give_verdict();
  end
endmodule
`default_nettype wire
